// [ipr_map.vh]
`ifndef IPR_MAP_VH
`define IPR_MAP_VH
`define IPR_CODE_W        6
`define IPR_OFS_W         6
`define IPR_PRI_W         4
`define IPR_CODE_NONE     6'h3F
`define IPR_CODE_GFXPORT  6'h23
`define IPR_PRI_GFXPORT   4'h5
`define IPR_PRI_INTERNAL  4'h8
`define IPR_OFS_UE        6'h2E
`define IPR_OFS_CE        6'h2F
`define IPR_OFS_BUSERR    6'h30
`define IPR_PKT_BYTES     24
`define IPR_PKT_BEATS     6
`define IPR_BEAT_W        32
`define IPR_PKT_MARK      8'hA5
`define IPR_NUM_INT       3
`define IPR_LVL_SLOTS     64
`endif

// [ipr_code_decode.v]
`timescale 1ns/10ps
`include "ipr_map.vh"
module ipr_code_decode (
   input  wire [5:0] code_in,
   output reg        valid_out,
   output reg        pulse_out,
   output reg  [5:0] offset_out,
   output reg  [3:0] prio_out
);
   // Source code to mapping offset and priority
   always @* begin
      valid_out  = 1'b1;
      pulse_out  = 1'b0;
      offset_out = 6'h00;
      prio_out   = 4'h0;
      case (code_in)
         6'h07: {offset_out, prio_out} = {6'h00, 4'h7};
         6'h05: {offset_out, prio_out} = {6'h01, 4'h5};
         6'h02: {offset_out, prio_out} = {6'h03, 4'h2};
         6'h0F: {offset_out, prio_out} = {6'h04, 4'h7};
         6'h0D: {offset_out, prio_out} = {6'h05, 4'h5};
         6'h1D: {offset_out, prio_out} = {6'h06, 4'h5};
         6'h0A: {offset_out, prio_out} = {6'h07, 4'h2};
         6'h17: {offset_out, prio_out} = {6'h08, 4'h6};
         6'h38: {offset_out, prio_out} = {6'h09, 4'h5};
         6'h10: {offset_out, prio_out} = {6'h0A, 4'h2};
         6'h12: {offset_out, prio_out} = {6'h0B, 4'h1};
         6'h18: {offset_out, prio_out} = {6'h0C, 4'h6};
         6'h39: {offset_out, prio_out} = {6'h0D, 4'h5};
         6'h00: {offset_out, prio_out} = {6'h0E, 4'h2};
         6'h1A: {offset_out, prio_out} = {6'h0F, 4'h1};
         6'h06: {offset_out, prio_out} = {6'h10, 4'h6};
         6'h04: {offset_out, prio_out} = {6'h11, 4'h4};
         6'h03: {offset_out, prio_out} = {6'h12, 4'h3};
         6'h01: {offset_out, prio_out} = {6'h13, 4'h1};
         6'h0E: {offset_out, prio_out} = {6'h14, 4'h6};
         6'h0C: {offset_out, prio_out} = {6'h15, 4'h4};
         6'h0B: {offset_out, prio_out} = {6'h16, 4'h3};
         6'h09: {offset_out, prio_out} = {6'h17, 4'h1};
         6'h16: {offset_out, prio_out} = {6'h18, 4'h6};
         6'h14: {offset_out, prio_out} = {6'h19, 4'h4};
         6'h13: {offset_out, prio_out} = {6'h1A, 4'h3};
         6'h11: {offset_out, prio_out} = {6'h1B, 4'h1};
         6'h1E: {offset_out, prio_out} = {6'h1C, 4'h6};
         6'h1C: {offset_out, prio_out} = {6'h1D, 4'h4};
         6'h1B: {offset_out, prio_out} = {6'h1E, 4'h3};
         6'h19: {offset_out, prio_out} = {6'h1F, 4'h1};
         6'h20: {offset_out, prio_out} = {6'h20, 4'h3};
         6'h21: {offset_out, prio_out} = {6'h21, 4'h3};
         6'h22: {offset_out, prio_out} = {6'h22, 4'h2};
         6'h24: {offset_out, prio_out} = {6'h23, 4'h8};
         6'h1F: {offset_out, prio_out} = {6'h24, 4'h7};
         6'h25: {offset_out, prio_out} = {6'h25, 4'h8};
         6'h28: {offset_out, prio_out} = {6'h26, 4'h7};
         6'h29: {offset_out, prio_out} = {6'h27, 4'h8};
         6'h2A: {offset_out, prio_out} = {6'h28, 4'h2};
         6'h2B: {offset_out, prio_out} = {6'h29, 4'h4};
         6'h2C: {offset_out, prio_out} = {6'h2A, 4'h4};
         6'h2D: {offset_out, prio_out} = {6'h2B, 4'h7};
         6'h23, 6'h26: begin
            pulse_out = 1'b1;
            prio_out  = `IPR_PRI_GFXPORT;
         end
         default: valid_out = 1'b0;
      endcase
   end
endmodule

// [ipr_router.v]
`timescale 1ns/10ps
`include "ipr_map.vh"
// What this block does
// - Interrupts reach CPU only as 24-byte packets
// - Level acknowledge interrupts become packets, no wires
// - Source code registered, then synchronised before use
// - Slot pins map to offsets 0x10-0x1F
// - Graphics controller code 0x1A maps offset 0x0F
// - Disk, network, parallel, audio sources mapped
// - Power fail, diskette, spare, keyboard, mouse, serial mapped
// - Internal memory and bus errors fixed offsets
// - Graphics port pulse uses offset register value
// - Code 0x3F means nothing pending, no packet
module ipr_router #(
   parameter BEAT_W = `IPR_BEAT_W
) (
   input  wire              core_clk_in,
   input  wire              nrst_in,
   input  wire [5:0]        source_code_in,
   input  wire              mem_uncorr_err_in,
   input  wire              mem_corr_err_in,
   input  wire              pci_bus_err_in,
   input  wire [5:0]        graphics_offset_register_in,
   input  wire              ack_valid_in,
   input  wire [5:0]        ack_offset_in,
   input  wire              pkt_ready_in,
   output reg               pkt_valid_out,
   output reg               pkt_last_out,
   output reg  [BEAT_W-1:0] pkt_data_out
);
   localparam ST_IDLE = 2'b00;
   localparam ST_SEND = 2'b01;

   reg  [5:0]  code_cap_r;
   reg  [5:0]  code_s1_r;
   reg  [5:0]  code_s2_r;
   reg  [2:0]  err_s1_r;
   reg  [2:0]  err_s2_r;
   reg  [5:0]  gfx_s1_r;
   reg  [5:0]  gfx_s2_r;
   reg  [5:0]  gfx_code_prev_r;
   reg  [63:0] pend_r;
   reg  [63:0] pend_nxt;
   reg  [1:0]  state_r;
   reg  [2:0]  beat_r;
   reg  [5:0]  pkt_ofs_r;
   reg  [3:0]  pkt_pri_r;
   reg         pkt_pulse_r;
   wire        dec_valid;
   wire        dec_pulse;
   wire [5:0]  dec_ofs;
   wire [3:0]  dec_pri;
   reg         sel_ok;
   reg  [5:0]  sel_ofs;
   reg  [3:0]  sel_pri;
   reg         sel_pulse;
   wire        gfx_pulse_evt;
   reg  [5:0]  code_old_r;
   wire        code_steady;
   reg         gfx_hold_r;
   reg  [5:0]  gfx_hold_ofs_r;

   ipr_code_decode u_dec (
      .code_in    (code_s2_r),
      .valid_out  (dec_valid),
      .pulse_out  (dec_pulse),
      .offset_out (dec_ofs),
      .prio_out   (dec_pri)
   );

   // Only beat 0 carries fields; the rest pad to 24 bytes
   function [BEAT_W-1:0] beat_word;
      input [2:0] idx;
      input [5:0] ofs;
      input [3:0] pri;
      input       pls;
      begin
         beat_word = {BEAT_W{1'b0}};
         if (idx == 3'h0)
            beat_word = {`IPR_PKT_MARK, 11'h000, pls, pri, 2'h0, ofs};
      end
   endfunction

   // Code bits may skew across the crossing; use a code once it holds two cycles
   assign code_steady = (code_s2_r == gfx_code_prev_r);
   // Pulse is a steady code newly entering a pulse code
   assign gfx_pulse_evt = dec_valid && dec_pulse && code_steady && (gfx_code_prev_r != code_old_r);

   // Capture code, then two-stage synchronise code, errors and offset value
   always @(posedge core_clk_in) begin
      if (!nrst_in) begin
         code_cap_r      <= `IPR_CODE_NONE;
         code_s1_r       <= `IPR_CODE_NONE;
         code_s2_r       <= `IPR_CODE_NONE;
         gfx_code_prev_r <= `IPR_CODE_NONE;
         code_old_r      <= `IPR_CODE_NONE;
         err_s1_r        <= 3'h0;
         err_s2_r        <= 3'h0;
         gfx_s1_r        <= 6'h00;
         gfx_s2_r        <= 6'h00;
      end else begin
         code_cap_r      <= source_code_in;
         code_s1_r       <= code_cap_r;
         code_s2_r       <= code_s1_r;
         gfx_code_prev_r <= code_s2_r;
         code_old_r      <= gfx_code_prev_r;
         err_s1_r        <= {pci_bus_err_in, mem_corr_err_in, mem_uncorr_err_in};
         err_s2_r        <= err_s1_r;
         gfx_s1_r        <= graphics_offset_register_in;
         gfx_s2_r        <= gfx_s1_r;
      end
   end

   // Keep a graphics pulse until its packet starts; a busy link would drop it
   always @(posedge core_clk_in) begin
      if (!nrst_in) begin
         gfx_hold_r     <= 1'b0;
         gfx_hold_ofs_r <= 6'h00;
      end else if (gfx_pulse_evt) begin
         gfx_hold_r     <= 1'b1;
         gfx_hold_ofs_r <= gfx_s2_r;
      end else if (state_r == ST_IDLE && sel_ok && sel_pulse) begin
         gfx_hold_r     <= 1'b0;
      end
   end

   // Pick next source: internal errors first, then held graphics pulse, then external level
   always @* begin
      sel_ok    = 1'b0;
      sel_ofs   = 6'h00;
      sel_pri   = 4'h0;
      sel_pulse = 1'b0;
      if (err_s2_r[0] && !pend_r[`IPR_OFS_UE]) begin
         sel_ok  = 1'b1;
         sel_ofs = `IPR_OFS_UE;
         sel_pri = `IPR_PRI_INTERNAL;
      end else if (err_s2_r[1] && !pend_r[`IPR_OFS_CE]) begin
         sel_ok  = 1'b1;
         sel_ofs = `IPR_OFS_CE;
         sel_pri = `IPR_PRI_INTERNAL;
      end else if (err_s2_r[2] && !pend_r[`IPR_OFS_BUSERR]) begin
         sel_ok  = 1'b1;
         sel_ofs = `IPR_OFS_BUSERR;
         sel_pri = `IPR_PRI_INTERNAL;
      end else if (gfx_hold_r) begin
         sel_ok    = 1'b1;
         sel_ofs   = gfx_hold_ofs_r;
         sel_pri   = `IPR_PRI_GFXPORT;
         sel_pulse = 1'b1;
      end else if (code_steady && dec_valid && !dec_pulse && !pend_r[dec_ofs]) begin
         sel_ok  = 1'b1;
         sel_ofs = dec_ofs;
         sel_pri = dec_pri;
      end
   end

   // Pending set when a level packet starts, cleared by acknowledge
   always @* begin
      pend_nxt = pend_r;
      if (ack_valid_in)
         pend_nxt[ack_offset_in] = 1'b0;
      if (state_r == ST_IDLE && sel_ok && !sel_pulse)
         pend_nxt[sel_ofs] = 1'b1;
   end

   // Six 32-bit beats form one 24-byte packet write
   always @(posedge core_clk_in) begin
      if (!nrst_in) begin
         pend_r        <= 64'h0000000000000000;
         state_r       <= ST_IDLE;
         beat_r        <= 3'h0;
         pkt_ofs_r     <= 6'h00;
         pkt_pri_r     <= 4'h0;
         pkt_pulse_r   <= 1'b0;
         pkt_valid_out <= 1'b0;
         pkt_last_out  <= 1'b0;
         pkt_data_out  <= {BEAT_W{1'b0}};
      end else begin
         pend_r <= pend_nxt;
         case (state_r)
            ST_IDLE: begin
               // Beat 0 goes out as soon as a source wins
               if (sel_ok) begin
                  state_r       <= ST_SEND;
                  beat_r        <= 3'h0;
                  pkt_ofs_r     <= sel_ofs;
                  pkt_pri_r     <= sel_pri;
                  pkt_pulse_r   <= sel_pulse;
                  pkt_valid_out <= 1'b1;
                  pkt_last_out  <= 1'b0;
                  pkt_data_out  <= beat_word(3'h0, sel_ofs, sel_pri, sel_pulse);
               end
            end
            ST_SEND: begin
               // Each beat stands until ready is seen
               if (pkt_ready_in) begin
                  if (beat_r == (`IPR_PKT_BEATS - 1)) begin
                     state_r       <= ST_IDLE;
                     pkt_valid_out <= 1'b0;
                     pkt_last_out  <= 1'b0;
                     pkt_data_out  <= {BEAT_W{1'b0}};
                  end else begin
                     beat_r       <= beat_r + 3'h1;
                     pkt_last_out <= (beat_r == (`IPR_PKT_BEATS - 2));
                     pkt_data_out <= beat_word(beat_r + 3'h1, pkt_ofs_r, pkt_pri_r, pkt_pulse_r);
                  end
               end
            end
            default: begin
               // Unknown state: abandon the packet and idle
               state_r       <= ST_IDLE;
               pkt_valid_out <= 1'b0;
               pkt_last_out  <= 1'b0;
               pkt_data_out  <= {BEAT_W{1'b0}};
            end
         endcase
      end
   end
endmodule

// [ipr_router_properties.sv]
`timescale 1ns/10ps
module ipr_router_chk #(
   parameter BEAT_W = 32
) (
   input wire              core_clk_in,
   input wire              nrst_in,
   input wire              pkt_ready_in,
   input wire              pkt_valid_out,
   input wire              pkt_last_out,
   input wire [BEAT_W-1:0] pkt_data_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   reg [2:0] beat_r;
   wire      take = pkt_valid_out && pkt_ready_in;
   always @(posedge core_clk_in) begin
      if (!nrst_in) beat_r <= 3'h0;
      else if (take) beat_r <= pkt_last_out ? 3'h0 : beat_r + 3'h1;
   end
   a_beat_hold: assert property (pkt_valid_out && !pkt_ready_in |=> pkt_valid_out && $stable(pkt_data_out))
      else $error("beat changed while stalled");
   a_last_end: assert property (take && pkt_last_out |=> !pkt_valid_out)
      else $error("no idle cycle after last beat");
   a_last_pos: assert property (pkt_valid_out |-> pkt_last_out == (beat_r == 3'h5))
      else $error("last flag not on sixth beat");
   a_tail_zero: assert property (pkt_valid_out && beat_r != 3'h0 |-> pkt_data_out == 0)
      else $error("tail beat not zero");
   a_head_mark: assert property ($rose(pkt_valid_out) |-> pkt_data_out[31:24] == 8'hA5)
      else $error("packet marker wrong");
   a_int_prio: assert property ($rose(pkt_valid_out) && !pkt_data_out[12] &&
      pkt_data_out[5:0] inside {6'h2E, 6'h2F, 6'h30} |-> pkt_data_out[11:8] == 4'h8)
      else $error("internal source priority wrong");
   a_slot_prio: assert property ($rose(pkt_valid_out) && !pkt_data_out[12] && pkt_data_out[5:4] == 2'h1 |->
      pkt_data_out[11:8] == (pkt_data_out[1:0] == 2'h0 ? 4'h6 : pkt_data_out[1:0] == 2'h1 ? 4'h4 :
      pkt_data_out[1:0] == 2'h2 ? 4'h3 : 4'h1))
      else $error("slot pin priority wrong");
   a_gfx_pulse: assert property ($rose(pkt_valid_out) && pkt_data_out[12] |-> pkt_data_out[11:8] == 4'h5)
      else $error("pulse priority wrong");
endmodule
bind ipr_router ipr_router_chk #(.BEAT_W(BEAT_W)) chk (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
   .pkt_ready_in(pkt_ready_in), .pkt_valid_out(pkt_valid_out), .pkt_last_out(pkt_last_out),
   .pkt_data_out(pkt_data_out));

// [ipr_cpu_model.sv]
`timescale 1ns/10ps
module ipr_cpu_model (
   input  wire        clk_in,
   input  wire        stall_in,
   input  wire        valid_in,
   input  wire        last_in,
   input  wire [31:0] data_in,
   output logic       ready_out,
   output logic [31:0] head_out,
   output logic [7:0] npk_out,
   output logic [3:0] beats_out
);
   logic [3:0] bi_r = 4'h0;
   initial begin
      ready_out = 1'b1;
      head_out = 32'h0;
      npk_out = 8'h0;
      beats_out = 4'h0;
   end
   // Stall drops ready every other cycle
   always @(negedge clk_in) ready_out <= stall_in ? ~ready_out : 1'b1;
   always @(posedge clk_in) begin
      if (valid_in && ready_out) begin
         if (bi_r == 4'h0) head_out <= data_in;
         bi_r <= last_in ? 4'h0 : bi_r + 4'h1;
         if (last_in) begin
            beats_out <= bi_r + 4'h1;
            npk_out <= npk_out + 8'h1;
         end
      end
   end
endmodule

// [interrupt_packet_router_tb.sv]
`timescale 1ns/10ps
module interrupt_packet_router_tb;
   logic clk = 0, nrst = 0, ue = 0, ce = 0, be = 0, ackv = 0, stall = 0, rdy, v, l;
   logic [5:0] code = 6'h3F, gofs = 6'h00, acko = 6'h00;
   logic [31:0] d, hd;
   logic [7:0] npk;
   logic [3:0] nb;
   int err_count = 0, tests_run = 0, cyc = 0;
   logic [23:0] tab [17] = '{24'h061006, 24'h041104, 24'h011301, 24'h191F01, 24'h1A0F01,
      24'h202003, 24'h242308, 24'h1F2407, 24'h222202, 24'h252508, 24'h292708, 24'h2A2802,
      24'h2B2904, 24'h2C2A04, 24'h2D2B07, 24'h212103, 24'h070007};
   always #20 clk = ~clk;
   ipr_router uut (.core_clk_in(clk), .nrst_in(nrst), .source_code_in(code), .mem_uncorr_err_in(ue),
      .mem_corr_err_in(ce), .pci_bus_err_in(be), .graphics_offset_register_in(gofs), .ack_valid_in(ackv),
      .ack_offset_in(acko), .pkt_ready_in(rdy), .pkt_valid_out(v), .pkt_last_out(l), .pkt_data_out(d));
   ipr_cpu_model cpu (.clk_in(clk), .stall_in(stall), .valid_in(v), .last_in(l), .data_in(d),
      .ready_out(rdy), .head_out(hd), .npk_out(npk), .beats_out(nb));
   function automatic [31:0] hexp(input [5:0] o, input [3:0] p, input s);
      hexp = {8'hA5, 11'h0, s, p, 2'b00, o};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("errors %0d of %0d checks", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wait_pkt(input int lim, output logic got);
      logic [7:0] p0;
      int n;
      p0 = npk;
      n = 0;
      while (npk === p0 && n < lim) begin
         @(negedge clk);
         n++;
      end
      got = (npk !== p0);
   endtask
   task automatic ack(input [5:0] o);
      repeat (6) @(negedge clk);
      acko = o;
      ackv = 1;
      @(negedge clk);
      ackv = 0;
   endtask
   task automatic t_map;
      logic g;
      for (int i = 0; i < 17; i++) begin
         code = tab[i][21:16];
         wait_pkt(200, g);
         check(g, 1'b1);
         check(hd, hexp(tab[i][13:8], tab[i][3:0], 1'b0));
         check(nb, 4'h6);
         code = 6'h3F;
         ack(tab[i][13:8]);
      end
   endtask
   task automatic t_hold;
      logic g;
      code = 6'h06;
      wait_pkt(200, g);
      wait_pkt(60, g);
      check(g, 1'b0);
      ack(6'h10);
      wait_pkt(200, g);
      check(g, 1'b1);
      code = 6'h3F;
      ack(6'h10);
      wait_pkt(60, g);
      check(g, 1'b0);
   endtask
   task automatic t_int;
      logic g;
      stall = 1;
      for (int i = 0; i < 3; i++) begin
         {ue, ce, be} = 3'b100 >> i;
         wait_pkt(200, g);
         check(hd, hexp(6'h2E + i[5:0], 4'h8, 1'b0));
         {ue, ce, be} = 3'b000;
         ack(6'h2E + i[5:0]);
      end
   endtask
   task automatic t_gfx;
      logic g;
      gofs = 6'h33;
      ue = 1;
      code = 6'h23;
      wait_pkt(200, g);
      check(hd, hexp(6'h2E, 4'h8, 1'b0));
      ue = 0;
      wait_pkt(200, g);
      check(hd, hexp(6'h33, 4'h5, 1'b1));
      wait_pkt(60, g);
      check(g, 1'b0);
      code = 6'h3F;
      ack(6'h2E);
      stall = 0;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         complete_run;
      end
   end
   initial begin
      repeat (2) @(negedge clk);
      nrst = 1;
      check(v, 1'b0);
      repeat (4) @(negedge clk);
      t_map;
      t_hold;
      t_int;
      t_gfx;
      complete_run;
   end
endmodule
